// ### hdl/cpu_cfg_pkg.sv
/*
  Constants, field positions and carrier types for the processor configuration bank.
  Assumes a single 250 MHz core clock and a 32-bit Avalon-MM register port.
*/
package cpu_cfg_pkg;

  // Register byte offsets
  localparam logic [5:0] OFS_POWER_PROT  = 6'h00;
  localparam logic [5:0] OFS_MAP_SMM     = 6'h04;
  localparam logic [5:0] OFS_IO_RECOVERY = 6'h08;
  localparam logic [5:0] OFS_SMM_PINS    = 6'h0C;
  localparam logic [5:0] OFS_REGION3     = 6'h10;
  localparam logic [5:0] OFS_STATUS      = 6'h14;

  // power_protection_config fields
  localparam int BIT_NW_LOCK          = 2;
  localparam int BIT_SUSPEND_ON_HALT  = 3;
  localparam int BIT_LOW_REGION_WP    = 4;
  localparam int BIT_SUSPEND_PINS_EN  = 7;
  localparam logic [7:0] MASK_POWER_PROT = 8'h9C;

  // map_smm_burst_config fields
  localparam int BIT_SMM_CONFIG_LOCK  = 0;
  localparam int BIT_NMI_IN_SMM_EN    = 1;
  localparam int BIT_LINEAR_BURST     = 2;
  localparam int POS_EXT_MAP          = 4;
  localparam logic [7:0] MASK_MAP_SMM = 8'hF7;
  localparam logic [3:0] EXT_MAP_ALL  = 4'h1;

  // io_recovery_config fields
  localparam int POS_IO_RECOVERY       = 0;
  localparam int BIT_DTE_CACHE_EN      = 4;
  localparam int BIT_IDENTIFY_EN       = 7;
  localparam logic [7:0] MASK_IO_RECOVERY = 8'h97;
  localparam logic [2:0] IO_RECOVERY_RST  = 3'h5;
  localparam logic [2:0] IO_RECOVERY_NONE = 3'h7;

  // smm pin and region control fields
  localparam int BIT_SMM_PINS_EN      = 1;
  localparam int BIT_SMM_MEM_ACCESS   = 2;
  localparam int BIT_REGION3_SMM      = 7;
  localparam logic [7:0] MASK_SMM_PINS = 8'h86;
  localparam logic [3:0] REGION_SIZE_OFF  = 4'h0;
  localparam logic [3:0] REGION_SIZE_FULL = 4'hF;

  // Reset values
  localparam logic [7:0]  RST_POWER_PROT  = 8'h00;
  localparam logic [7:0]  RST_MAP_SMM     = 8'h00;
  localparam logic [7:0]  RST_IO_RECOVERY = {5'h00, IO_RECOVERY_RST};
  localparam logic [7:0]  RST_SMM_PINS    = 8'h00;
  localparam logic [23:0] RST_REGION3     = 24'h000000;

  // Low memory window 640 KByte to 1 MByte
  localparam logic [31:0] LOW_REGION_BASE = 32'h000A_0000;
  localparam logic [31:0] LOW_REGION_END  = 32'h0010_0000;
  localparam logic [31:0] REGION_UNIT     = 32'h0000_1000;

  // Core memory access carrier
  typedef struct packed {
    logic        valid;
    logic        cacheable;
    logic [31:0] addr;
  } mem_access_s;

  // Burst sequencer modes
  typedef enum logic [1:0] {BURST_IDLE, BURST_RUN} burst_state_e;

endpackage

// ### hdl/burst_addr_seq.sv
/*
  Burst beat address generator for four-beat line fills.
  Assumes start_i is a one-cycle pulse and beats advance every clock.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_addr_seq #(
  parameter int BEATS_W = 2
) (
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_n_i,
  // Control
  input  wire logic               start_i,
  input  wire logic               linear_i,
  input  wire logic [BEATS_W-1:0] first_beat_i,
  // Beat output
  output logic                    beat_valid_o,
  output logic [BEATS_W-1:0]      beat_addr_o
);

  cpu_cfg_pkg::burst_state_e state_r;
  logic [BEATS_W-1:0]        first_r;
  logic [BEATS_W-1:0]        count_r;
  logic                      linear_r;
  logic                      last_beat;
  logic [BEATS_W-1:0]        beat_addr_nxt;

  assign last_beat     = (count_r == {BEATS_W{1'b1}});
  assign beat_addr_nxt = linear_r ? BEATS_W'(first_r + count_r) : (first_r ^ count_r);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r      <= cpu_cfg_pkg::BURST_IDLE;
      first_r      <= '0;
      count_r      <= '0;
      linear_r     <= 1'b0;
      beat_valid_o <= 1'b0;
      beat_addr_o  <= '0;
    end else begin
      unique case (state_r)
        cpu_cfg_pkg::BURST_IDLE: begin
          beat_valid_o <= 1'b0;
          count_r      <= '0;
          if (start_i) begin
            first_r  <= first_beat_i;
            linear_r <= linear_i;
            state_r  <= cpu_cfg_pkg::BURST_RUN;
          end
        end
        cpu_cfg_pkg::BURST_RUN: begin
          beat_valid_o <= 1'b1;
          beat_addr_o  <= beat_addr_nxt;
          count_r      <= BEATS_W'(count_r + 1'b1);
          if (last_beat) begin
            state_r <= cpu_cfg_pkg::BURST_IDLE;
          end
        end
      endcase
    end
  end

endmodule // burst_addr_seq
`default_nettype wire

// ### hdl/io_recovery_gap.sv
/*
  Minimum bus clock gap enforcer between I/O accesses.
  Assumes bus_tick_i is a one-cycle enable per bus clock and io_done_i marks an I/O end.
*/
`timescale 1ns/1ps
`default_nettype none
module io_recovery_gap #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       bus_tick_i,
  input  wire logic [2:0] recovery_i,
  input  wire logic       io_done_i,
  // Status
  output logic            io_ready_o
);

  logic [CNT_W-1:0] gap_r;
  logic [CNT_W-1:0] gap_len;
  logic             no_delay;

  assign no_delay = (recovery_i == cpu_cfg_pkg::IO_RECOVERY_NONE);
  assign gap_len  = CNT_W'(1) << recovery_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_r      <= '0;
      io_ready_o <= 1'b1;
    end else begin
      if (io_done_i && !no_delay) begin
        gap_r      <= gap_len;
        io_ready_o <= 1'b0;
      end else if (bus_tick_i && gap_r != '0) begin
        gap_r      <= CNT_W'(gap_r - 1'b1);
        io_ready_o <= (gap_r == CNT_W'(1));
      end else if (gap_r == '0) begin
        io_ready_o <= 1'b1;
      end
    end
  end

endmodule // io_recovery_gap
`default_nettype wire

// ### hdl/cpu_config_control_bank.sv
/*
  Processor configuration bank: power and protection, map, SYSTEM_MANAGEMENT_MODE lock, burst order,
  I/O recovery, directory cache and identification controls behind an Avalon-MM slave.
  Assumes core strobes are synchronous to clk_sys_i and smm_active_i marks SYSTEM_MANAGEMENT_INTERRUPT service.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_config_control_bank #(
  parameter int BUS_DIV = 4
) (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  // Avalon-MM slave
  input  wire logic [5:0]               avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic [31:0]                   avs_readdata_o,
  output logic                          avs_waitrequest_o,
  // Core events
  input  wire logic                     smm_active_i,
  input  wire logic                     halt_exec_i,
  input  wire logic                     wake_i,
  input  wire logic                     nmi_i,
  input  wire logic                     nw_write_i,
  input  wire logic                     nw_wdata_i,
  input  wire logic                     query_flag_write_i,
  input  wire logic                     query_flag_wdata_i,
  input  wire logic                     identify_exec_i,
  input  wire cpu_cfg_pkg::mem_access_s access_i,
  input  wire logic                     io_done_i,
  input  wire logic                     burst_start_i,
  input  wire logic [1:0]               burst_first_i,
  input  wire logic [7:0]               cfg_index_i,
  // Suspend pins
  input  wire logic                     suspend_request_in_n_i,
  output logic                          suspend_ack_out_n_o,
  output logic                          suspend_ack_out_oe_o,
  // Core controls
  output logic                          cache_writethrough_disable_o,
  output logic                          processor_query_flag_o,
  output logic                          identify_ok_o,
  output logic                          invalid_opcode_o,
  output logic                          suspend_state_o,
  output logic                          write_protect_o,
  output logic                          smm_region_hit_o,
  output logic                          nmi_take_o,
  output logic                          cfg_index_visible_o,
  output logic                          dte_cache_enable_o,
  output logic                          smm_pins_enable_o,
  output logic                          smm_memory_access_o,
  output logic                          io_ready_o,
  output logic                          burst_valid_o,
  output logic [1:0]                    burst_addr_o
);

  // Index visibility under the map setting
  function automatic logic index_visible(input logic [7:0] idx, input logic [3:0] map);
    index_visible = (map == cpu_cfg_pkg::EXT_MAP_ALL) ||
                    (idx >= 8'hC0 && idx <= 8'hCF) || idx == 8'hFE || idx == 8'hFF;
  endfunction

  // Byte-enable merge
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wdata,
                                            input logic en, input logic [7:0] mask);
    merge_byte = en ? (wdata & mask) : old;
  endfunction

  // Region three match
  function automatic logic region_hit(input logic [31:0] addr, input logic [23:0] reg3);
    logic [31:0] base;
    logic [31:0] span;
    base = {reg3[23:4], 12'h000};
    span = (cpu_cfg_pkg::REGION_UNIT << (reg3[3:0] - 4'h1)) - 32'h1;
    if (reg3[3:0] == cpu_cfg_pkg::REGION_SIZE_OFF) begin
      region_hit = 1'b0;
    end else if (reg3[3:0] == cpu_cfg_pkg::REGION_SIZE_FULL) begin
      region_hit = 1'b1;
    end else begin
      region_hit = ((addr ^ base) & ~span) == 32'h0;
    end
  endfunction

  logic [7:0]  power_prot_r;
  logic [7:0]  map_smm_r;
  logic [7:0]  io_recovery_r;
  logic [7:0]  smm_pins_r;
  logic [23:0] region3_r;
  logic        pin_suspend_r;
  logic [7:0]  div_r;
  logic        bus_tick_r;
  logic        io_ready;

  // Bus decode
  wire        bus_req    = avs_read_i | avs_write_i;
  wire        bus_accept = bus_req & ~avs_waitrequest_o;
  wire        wr_en      = avs_write_i & bus_accept;
  wire        hit_power  = (avs_address_i == cpu_cfg_pkg::OFS_POWER_PROT);
  wire        hit_map    = (avs_address_i == cpu_cfg_pkg::OFS_MAP_SMM);
  wire        hit_io     = (avs_address_i == cpu_cfg_pkg::OFS_IO_RECOVERY);
  wire        hit_pins   = (avs_address_i == cpu_cfg_pkg::OFS_SMM_PINS);
  wire        hit_reg3   = (avs_address_i == cpu_cfg_pkg::OFS_REGION3);
  wire        hit_status = (avs_address_i == cpu_cfg_pkg::OFS_STATUS);
  wire [3:0]  ext_map    = map_smm_r[cpu_cfg_pkg::POS_EXT_MAP +: 4];
  wire        io_exposed = (ext_map == cpu_cfg_pkg::EXT_MAP_ALL);
  wire        smm_locked = map_smm_r[cpu_cfg_pkg::BIT_SMM_CONFIG_LOCK];
  wire        smm_wr_ok  = ~smm_locked | smm_active_i;
  wire        pins_en    = power_prot_r[cpu_cfg_pkg::BIT_SUSPEND_PINS_EN];
  wire        suspend_request_in_req   = pins_en & ~suspend_request_in_n_i;

  // Locked bits keep their value outside SYSTEM_MANAGEMENT_MODE; lock bit is sticky
  wire [7:0]  map_keep   = smm_wr_ok ? 8'h00 : (8'h01 << cpu_cfg_pkg::BIT_NMI_IN_SMM_EN);
  wire [7:0]  map_new    = merge_byte(map_smm_r, avs_writedata_i[7:0], avs_byteenable_i[0],
                                      cpu_cfg_pkg::MASK_MAP_SMM);
  wire [7:0]  map_nxt    = (map_new & ~map_keep) | (map_smm_r & map_keep) |
                           (map_smm_r & (8'h01 << cpu_cfg_pkg::BIT_SMM_CONFIG_LOCK));
  wire [23:0] reg3_nxt   = {merge_byte(region3_r[23:16], avs_writedata_i[23:16], avs_byteenable_i[2], 8'hFF),
                            merge_byte(region3_r[15:8], avs_writedata_i[15:8], avs_byteenable_i[1], 8'hFF),
                            merge_byte(region3_r[7:0], avs_writedata_i[7:0], avs_byteenable_i[0], 8'hFF)};

  wire [31:0] status_word = {28'h0, smm_locked, ~io_ready, pin_suspend_r, suspend_state_o};
  wire [31:0] rd_mux = hit_power  ? {24'h0, power_prot_r} :
                       hit_map    ? {24'h0, map_smm_r} :
                       (hit_io && io_exposed) ? {24'h0, io_recovery_r} :
                       hit_pins   ? {24'h0, smm_pins_r} :
                       hit_reg3   ? {8'h0, region3_r} :
                       hit_status ? status_word : 32'h0;

  // Avalon slave handshake
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // Register writes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_prot_r  <= cpu_cfg_pkg::RST_POWER_PROT;
      map_smm_r     <= cpu_cfg_pkg::RST_MAP_SMM;
      io_recovery_r <= cpu_cfg_pkg::RST_IO_RECOVERY;
      smm_pins_r    <= cpu_cfg_pkg::RST_SMM_PINS;
      region3_r     <= cpu_cfg_pkg::RST_REGION3;
    end else if (wr_en) begin
      if (hit_power) begin
        power_prot_r <= merge_byte(power_prot_r, avs_writedata_i[7:0], avs_byteenable_i[0],
                                   cpu_cfg_pkg::MASK_POWER_PROT);
      end
      if (hit_map) begin
        map_smm_r <= map_nxt;
      end
      if (hit_io && io_exposed) begin
        io_recovery_r <= merge_byte(io_recovery_r, avs_writedata_i[7:0], avs_byteenable_i[0],
                                    cpu_cfg_pkg::MASK_IO_RECOVERY);
      end
      if (hit_pins && smm_wr_ok) begin
        smm_pins_r <= merge_byte(smm_pins_r, avs_writedata_i[7:0], avs_byteenable_i[0],
                                 cpu_cfg_pkg::MASK_SMM_PINS);
      end
      if (hit_reg3 && smm_wr_ok) begin
        region3_r <= reg3_nxt;
      end
    end
  end

  // Core side flags
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cache_writethrough_disable_o <= 1'b0;
      processor_query_flag_o       <= 1'b0;
      identify_ok_o                <= 1'b0;
      invalid_opcode_o             <= 1'b0;
    end else begin
      if (nw_write_i && !power_prot_r[cpu_cfg_pkg::BIT_NW_LOCK]) begin
        cache_writethrough_disable_o <= nw_wdata_i;
      end
      if (query_flag_write_i && io_recovery_r[cpu_cfg_pkg::BIT_IDENTIFY_EN]) begin
        processor_query_flag_o <= query_flag_wdata_i;
      end
      identify_ok_o    <= identify_exec_i & io_recovery_r[cpu_cfg_pkg::BIT_IDENTIFY_EN];
      invalid_opcode_o <= identify_exec_i & ~io_recovery_r[cpu_cfg_pkg::BIT_IDENTIFY_EN];
    end
  end

  // Suspend control
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      suspend_state_o      <= 1'b0;
      pin_suspend_r        <= 1'b0;
      suspend_ack_out_n_o  <= 1'b1;
      suspend_ack_out_oe_o <= 1'b0;
    end else begin
      if (halt_exec_i && power_prot_r[cpu_cfg_pkg::BIT_SUSPEND_ON_HALT]) begin
        suspend_state_o <= 1'b1;
      end else if (suspend_request_in_req) begin
        suspend_state_o <= 1'b1;
      end else if (wake_i || pin_suspend_r) begin
        suspend_state_o <= 1'b0;
      end
      pin_suspend_r        <= suspend_request_in_req;
      suspend_ack_out_oe_o <= pins_en;
      suspend_ack_out_n_o  <= ~(pins_en & suspend_state_o);
    end
  end

  // Access qualifiers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_protect_o     <= 1'b0;
      smm_region_hit_o    <= 1'b0;
      nmi_take_o          <= 1'b0;
      cfg_index_visible_o <= 1'b0;
      dte_cache_enable_o  <= 1'b0;
      smm_pins_enable_o   <= 1'b0;
      smm_memory_access_o <= 1'b0;
    end else begin
      write_protect_o     <= access_i.valid & access_i.cacheable &
                             power_prot_r[cpu_cfg_pkg::BIT_LOW_REGION_WP] &
                             (access_i.addr >= cpu_cfg_pkg::LOW_REGION_BASE) &
                             (access_i.addr < cpu_cfg_pkg::LOW_REGION_END);
      smm_region_hit_o    <= access_i.valid & smm_pins_r[cpu_cfg_pkg::BIT_REGION3_SMM] &
                             region_hit(access_i.addr, region3_r);
      nmi_take_o          <= nmi_i & (~smm_active_i | map_smm_r[cpu_cfg_pkg::BIT_NMI_IN_SMM_EN]);
      cfg_index_visible_o <= index_visible(cfg_index_i, ext_map);
      dte_cache_enable_o  <= io_recovery_r[cpu_cfg_pkg::BIT_DTE_CACHE_EN];
      smm_pins_enable_o   <= smm_pins_r[cpu_cfg_pkg::BIT_SMM_PINS_EN];
      smm_memory_access_o <= smm_pins_r[cpu_cfg_pkg::BIT_SMM_MEM_ACCESS];
    end
  end

  // Bus clock enable divider
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r      <= 8'h00;
      bus_tick_r <= 1'b0;
    end else begin
      bus_tick_r <= (div_r == 8'(BUS_DIV - 1));
      div_r      <= (div_r == 8'(BUS_DIV - 1)) ? 8'h00 : 8'(div_r + 8'h01);
    end
  end

  io_recovery_gap #(
    .CNT_W(7)
  ) u_io_gap (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .bus_tick_i (bus_tick_r),
    .recovery_i (io_recovery_r[cpu_cfg_pkg::POS_IO_RECOVERY +: 3]),
    .io_done_i  (io_done_i),
    .io_ready_o (io_ready)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_ready_o <= 1'b1;
    end else begin
      io_ready_o <= io_ready & ~io_done_i;
    end
  end

  burst_addr_seq #(
    .BEATS_W(2)
  ) u_burst (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .start_i      (burst_start_i),
    .linear_i     (map_smm_r[cpu_cfg_pkg::BIT_LINEAR_BURST]),
    .first_beat_i (burst_first_i),
    .beat_valid_o (burst_valid_o),
    .beat_addr_o  (burst_addr_o)
  );

endmodule // cpu_config_control_bank
`default_nettype wire

// ### bench/cpu_config_control_bank_sva.sv
/*
  Port-level assertions for the configuration bank.
  Assumes it is bound into cpu_config_control_bank and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_cfg_sva #(
  parameter int BUS_DIV = 4
) (
  // Clock and reset
  input wire logic                     clk_sys_i,
  input wire logic                     rst_n_i,
  // Register bus
  input wire logic                     avs_read_i,
  input wire logic                     avs_write_i,
  input wire logic                     avs_waitrequest_o,
  // Core side
  input wire logic                     identify_exec_i,
  input wire logic                     identify_ok_o,
  input wire logic                     invalid_opcode_o,
  input wire logic                     nmi_i,
  input wire logic                     nmi_take_o,
  input wire cpu_cfg_pkg::mem_access_s access_i,
  input wire logic                     write_protect_o,
  input wire logic                     io_done_i,
  input wire logic                     io_ready_o,
  input wire logic                     burst_start_i,
  input wire logic [1:0]               burst_first_i,
  input wire logic                     burst_valid_o,
  input wire logic [1:0]               burst_addr_o,
  input wire logic                     suspend_ack_out_n_o,
  input wire logic                     suspend_ack_out_oe_o
);
  localparam int GAP_MAX = 64 * BUS_DIV + 4;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // First beat, then the remaining three
  sequence s_first;
    burst_valid_o && burst_addr_o == $past(burst_first_i, 2);
  endsequence
  sequence s_rest;
    burst_valid_o [*3] ##1 !burst_valid_o;
  endsequence
  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");
  a_burst_beats: assert property (
    burst_start_i && !burst_valid_o && !$past(burst_start_i) |-> ##2 s_first ##1 s_rest)
    else $error("burst beats wrong");
  a_wp_cause: assert property (
    write_protect_o |-> $past(access_i.cacheable && access_i.addr >= cpu_cfg_pkg::LOW_REGION_BASE
      && access_i.addr < cpu_cfg_pkg::LOW_REGION_END))
    else $error("write protect outside window");
  a_io_gap: assert property (
    io_done_i |=> !io_ready_o ##[1:GAP_MAX] io_ready_o)
    else $error("io gap wrong");
  a_identify_one: assert property (
    identify_exec_i |=> identify_ok_o != invalid_opcode_o)
    else $error("identify answer wrong");
  a_invop_cause: assert property (
    invalid_opcode_o |-> $past(identify_exec_i))
    else $error("stray invalid opcode");
  a_nmi_cause: assert property (
    nmi_take_o |-> $past(nmi_i))
    else $error("stray nmi take");
  a_ack_driven: assert property (
    !suspend_ack_out_n_o |-> suspend_ack_out_oe_o)
    else $error("ack low while floating");
endmodule // cpu_cfg_sva
bind cpu_config_control_bank cpu_cfg_sva #(.BUS_DIV(BUS_DIV)) cpu_cfg_sva_i (.clk_sys_i, .rst_n_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .identify_exec_i, .identify_ok_o, .invalid_opcode_o,
  .nmi_i, .nmi_take_o, .access_i, .write_protect_o, .io_done_i, .io_ready_o, .burst_start_i,
  .burst_first_i, .burst_valid_o, .burst_addr_o, .suspend_ack_out_n_o, .suspend_ack_out_oe_o);
`default_nettype wire

// ### bench/testbench.sv
/*
  Self-checking bench for the configuration bank.
  Assumes the bank alone, driven directly at its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  // nmi enable written only inside SYSTEM_MANAGEMENT_MODE
  logic clk_sys_i = '0, rst_n_i = '0, avs_read_i = '0, avs_write_i = '0, smm_active_i = '1;
  logic halt_exec_i = '0, wake_i = '0, nmi_i = '0, nw_write_i = '0, nw_wdata_i = '0;
  logic query_flag_write_i = '0, query_flag_wdata_i = '1, identify_exec_i = '0, io_done_i = '0;
  logic burst_start_i = '0, suspend_request_in_n_i = '1;
  logic [5:0] avs_address_i = '0;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [1:0] burst_first_i = '0, burst_addr_o;
  logic [7:0] cfg_index_i = '0;
  cpu_cfg_pkg::mem_access_s access_i = '0;
  logic avs_waitrequest_o, suspend_ack_out_n_o, suspend_ack_out_oe_o, cache_writethrough_disable_o;
  logic processor_query_flag_o, identify_ok_o, invalid_opcode_o, suspend_state_o, write_protect_o;
  logic smm_region_hit_o, nmi_take_o, cfg_index_visible_o, dte_cache_enable_o, smm_pins_enable_o;
  logic smm_memory_access_o, io_ready_o, burst_valid_o;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  row_s rows[5] = '{'{6'h04, 8'h1E, 8'h16}, '{6'h00, 8'hFF, 8'h9C}, '{6'h08, 8'hFF, 8'h97},
                    '{6'h18, 8'hFF, 8'h00}, '{6'h0C, 8'hFF, 8'h86}};
  cpu_config_control_bank #(.BUS_DIV(1)) cpu_config_control_bank_i (.clk_sys_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .smm_active_i, .halt_exec_i, .wake_i, .nmi_i, .nw_write_i, .nw_wdata_i,
    .query_flag_write_i, .query_flag_wdata_i, .identify_exec_i, .access_i, .io_done_i, .burst_start_i,
    .burst_first_i, .cfg_index_i, .suspend_request_in_n_i, .suspend_ack_out_n_o, .suspend_ack_out_oe_o,
    .cache_writethrough_disable_o, .processor_query_flag_o, .identify_ok_o, .invalid_opcode_o,
    .suspend_state_o, .write_protect_o, .smm_region_hit_o, .nmi_take_o, .cfg_index_visible_o,
    .dte_cache_enable_o, .smm_pins_enable_o, .smm_memory_access_o, .io_ready_o, .burst_valid_o,
    .burst_addr_o);
  always #2 clk_sys_i = !clk_sys_i;
  task results;
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i) if (++cyc == 20000) begin
    n_errors++;
    results();
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    step(1);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    do step(1); while (avs_waitrequest_o !== 1'h0);
    q = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask
  task pin(input logic s, input logic [1:0] e);
    suspend_request_in_n_i <= s;
    step(3);
    chk({suspend_state_o, suspend_ack_out_oe_o}, e);
  endtask
  task ev(input int k);
    {nmi_i, nw_wdata_i, nw_write_i, wake_i, halt_exec_i} <= {k == 4, k == 2, k == 2, k == 1, k == 0};
    {query_flag_write_i, identify_exec_i} <= {2{k == 5}};
    step(1);
    {halt_exec_i, wake_i, nw_write_i, nmi_i, query_flag_write_i, identify_exec_i} <= 6'h00;
    step(1);
  endtask
  task wp(input logic [31:0] ad, input logic c, input logic e);
    access_i <= '{1'h1, c, ad};
    step(2);
    chk(write_protect_o, e);
  endtask
  task ix(input logic [7:0] x, input logic e);
    cfg_index_i <= x;
    step(2);
    chk(cfg_index_visible_o, e);
  endtask
  task burst(input logic lin);
    burst_first_i <= 2'h1;
    burst_start_i <= 1'h1;
    step(1);
    burst_start_i <= 1'h0;
    step(1);
    for (int i = 0; i < 4; i++) begin
      step(1);
      chk({burst_valid_o, burst_addr_o}, {1'h1, lin ? 2'(1 + i) : 2'(1 ^ i)});
    end
  endtask
  task gap(input int n);
    int c;
    c = 0;
    io_done_i <= 1'h1;
    step(1);
    io_done_i <= 1'h0;
    repeat (80) begin
      step(1);
      c += int'(io_ready_o === 1'h0);
    end
    chk(c >= (n == 7 ? 0 : 1 << n) && c <= (n == 7 ? 1 : (1 << n) + 2), 1'h1);
  endtask
  initial begin
    step(6);
    rst_n_i <= 1'h1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    ev(2); chk(cache_writethrough_disable_o, 1'h0);
    foreach (rows[i]) wp({12'h000, 4'(i + 9), 16'hFFFF}, 1'h1, i inside {[1:5]});
    wp(32'h000B_0000, 1'h0, 1'h0);
    ix(8'hE8, 1'h1);
    burst(1'h1);
    smm_active_i <= 1'h1;
    ev(4); chk(nmi_take_o, 1'h1);
    ev(5); chk({processor_query_flag_o, identify_ok_o, invalid_opcode_o}, 3'h6);
    wr(6'h08, 8'h07);
    query_flag_wdata_i <= 1'h0;
    ev(5); chk({processor_query_flag_o, identify_ok_o, invalid_opcode_o}, 3'h5);
    wr(6'h00, 8'h00);
    ev(2); chk(cache_writethrough_disable_o, 1'h1);
    wr(6'h04, 8'h12);
    burst(1'h0);
    wr(6'h04, 8'h17);
    smm_active_i <= 1'h0;
    wr(6'h0C, 8'h00); rd(6'h0C, 8'h86);
    wr(6'h04, 8'h10); rd(6'h04, 8'h13);
    smm_active_i <= 1'h1;
    wr(6'h0C, 8'h00); rd(6'h0C, 8'h00);
    wr(6'h04, 8'h00); rd(6'h08, 8'h00);
    ix(8'hC2, 1'h1); ix(8'hE8, 1'h0); ix(8'hD0, 1'h0); ix(8'hFE, 1'h1);
    rst_n_i <= 1'h0;
    step(6);
    rst_n_i <= 1'h1;
    rd(6'h04, 8'h00);
    wr(6'h04, 8'h10);
    gap(5);
    for (int n = 0; n < 8; n++) begin
      wr(6'h08, 8'(n));
      gap(n);
    end
    wr(6'h08, 8'h10); step(2); chk(dte_cache_enable_o, 1'h1);
    wr(6'h0C, 8'h86); wr(6'h10, 8'h01);
    wp(32'h0000_0800, 1'h0, 1'h0); chk(smm_region_hit_o, 1'h1);
    chk({smm_pins_enable_o, smm_memory_access_o}, 2'h3);
    wp(32'h0000_1800, 1'h0, 1'h0); chk(smm_region_hit_o, 1'h0);
    pin(1'h0, 2'h0); pin(1'h1, 2'h0);
    wr(6'h00, 8'h88); step(2);
    pin(1'h0, 2'h3); chk(suspend_ack_out_n_o, 1'h0);
    rd(6'h14, 8'h03);
    pin(1'h1, 2'h1);
    ev(0); chk(suspend_state_o, 1'h1);
    ev(1); chk(suspend_state_o, 1'h0);
    results();
  end
endmodule // testbench
`default_nettype wire
